// ==== src/deep_sleep_clock_gate_bank0.v ====
// deep-sleep unit clock gate register with bus fault screening and events
//
// Contract
// - a gating bit at one gives its unit a clock, at zero the unit is unclocked and disabled.
// - an access to a unit whose clock is off is answered with a bus fault, not a normal completion.
// - gating bits leave reset at zero unless an exception is given for the bit.
// - the deep-sleep gating register is at 0x120, 32 bits wide, and resets to 0x00000040.
// - the register only governs unit clocks in deep sleep when auto clock gating is selected.
// - bit 24 is the read-write clock enable of the controller-area-network unit 0, reset zero.
// - bit 16 is the read-write clock enable of converter module 0, reset zero.
// - bits 9:8 select the converter rate, 0x2 for 500K, 0x1 for 250K, 0x0 for 125K, reset zero.
// - the rate selection never lets the converter run above its permitted maximum.
// - bit 6 is the read-write clock enable of the hibernation module.
// - bit 3 is the read-write clock enable of the watchdog, reset zero.
`timescale 1ns/1ps
`include "deep_sleep_clock_gate_map.vh"

module deep_sleep_clock_gate_bank0 #(
  parameter [1:0] MAX_RATE_CODE = `DSCG_RATE_500K,
  parameter ADDR_W = 12
) (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire [ADDR_W-1:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output wire [31:0] RDATA_O,
  input wire DEEP_SLEEP_I,
  input wire AUTO_CLOCK_GATING_SELECT_I,
  input wire [`DSCG_UNITS-1:0] RUN_UNIT_CLOCK_GATE_I,
  input wire [1:0] RUN_RATE_SELECT_I,
  input wire [`DSCG_UNITS-1:0] UNIT_ACCESS_I,
  output wire [`DSCG_UNITS-1:0] UNIT_CLK_EN_O,
  output wire [1:0] CONVERTER_RATE_O,
  output wire [`DSCG_UNITS-1:0] BUS_FAULT_O,
  output wire [`DSCG_UNITS-1:0] ACCESS_DONE_O,
  output wire IRQ_O
);

  // bit position of each unit's enable in the gating register
  function integer unit_bit;
    input integer unit;
    begin
      case (unit)
        `DSCG_UNIT_WDT: unit_bit = `DSCG_WDT_BIT;
        `DSCG_UNIT_HIB: unit_bit = `DSCG_HIB_BIT;
        `DSCG_UNIT_ADC: unit_bit = `DSCG_ADC_BIT;
        `DSCG_UNIT_CAN: unit_bit = `DSCG_CAN_BIT;
        default: unit_bit = 0;
      endcase
    end
  endfunction

  // clamp a rate code to the permitted maximum
  function [1:0] rate_limit;
    input [1:0] code;
    begin
      if (code > MAX_RATE_CODE) begin
        rate_limit = MAX_RATE_CODE;
      end else begin
        rate_limit = code;
      end
    end
  endfunction

  // address match used by both the write and the read path
  function hit;
    input [ADDR_W-1:0] addr;
    input [11:0] offset;
    begin
      hit = (addr == offset[ADDR_W-1:0]);
    end
  endfunction

  // one-hot positions of the mapped registers
  localparam SEL_GATE = 0;
  localparam SEL_STATUS = 1;
  localparam SEL_MASK = 2;
  localparam SEL_FAULT = 3;
  localparam SEL_APPLIED = 4;

  // one-hot register select, shared by the write and read decode
  function [4:0] reg_select;
    input [ADDR_W-1:0] addr;
    begin
      reg_select = 5'h00;
      if (hit(addr, `DSCG_GATE_OFFSET)) begin
        reg_select[SEL_GATE] = 1'b1;
      end
      if (hit(addr, `DSCG_STATUS_OFFSET)) begin
        reg_select[SEL_STATUS] = 1'b1;
      end
      if (hit(addr, `DSCG_MASK_OFFSET)) begin
        reg_select[SEL_MASK] = 1'b1;
      end
      if (hit(addr, `DSCG_FAULT_OFFSET)) begin
        reg_select[SEL_FAULT] = 1'b1;
      end
      if (hit(addr, `DSCG_APPLIED_OFFSET)) begin
        reg_select[SEL_APPLIED] = 1'b1;
      end
    end
  endfunction

  // register state
  reg [31:0] gate_r;
  reg [31:0] gate_nxt;
  reg [`DSCG_EV_W-1:0] status_r;
  reg [`DSCG_EV_W-1:0] status_nxt;
  reg [`DSCG_EV_W-1:0] mask_r;
  reg [1:0] fault_unit_r;
  reg [1:0] fault_unit_nxt;
  reg [7:0] fault_count_r;
  reg [7:0] fault_count_nxt;
  reg [31:0] rdata_r;
  reg [31:0] rdata_nxt;
  reg [`DSCG_UNITS-1:0] clk_en_r;
  reg [`DSCG_UNITS-1:0] clk_en_nxt;
  reg [1:0] rate_r;
  reg [1:0] rate_nxt;
  reg [`DSCG_UNITS-1:0] fault_r;
  reg [`DSCG_UNITS-1:0] done_r;
  reg sleep_gated_r;

  wire [4:0] sel;
  wire wr_gate;
  wire wr_status;
  wire wr_mask;
  wire [1:0] wr_rate;
  wire wr_clamped;

  // write decode; offsets are distinct so one strobe reaches one register
  assign sel = reg_select(ADDR_I);
  assign wr_gate = WR_I & sel[SEL_GATE];
  assign wr_status = WR_I & sel[SEL_STATUS];
  assign wr_mask = WR_I & sel[SEL_MASK];
  assign wr_rate = WDATA_I[`DSCG_RATE_HI:`DSCG_RATE_LO];
  // a too-fast rate code written to the gating register is flagged so software can see it was held back
  assign wr_clamped = wr_gate & (wr_rate > MAX_RATE_CODE);

  // deep-sleep settings apply only with auto clock gating selected
  wire sleep_gated;
  assign sleep_gated = DEEP_SLEEP_I & AUTO_CLOCK_GATING_SELECT_I;

  // per-unit enable source: deep-sleep bit or the run-mode enable
  wire [`DSCG_UNITS-1:0] deep_en;
  genvar g;
  generate
    for (g = 0; g < `DSCG_UNITS; g = g + 1) begin : g_unit
      assign deep_en[g] = gate_r[unit_bit(g)];
    end
  endgenerate

  // gating register update; reserved bits never take write data
  always @* begin
    gate_nxt = gate_r;
    if (wr_gate) begin
      gate_nxt = 32'h00000000;
      gate_nxt[`DSCG_CAN_BIT] = WDATA_I[`DSCG_CAN_BIT];
      gate_nxt[`DSCG_ADC_BIT] = WDATA_I[`DSCG_ADC_BIT];
      gate_nxt[`DSCG_HIB_BIT] = WDATA_I[`DSCG_HIB_BIT];
      gate_nxt[`DSCG_WDT_BIT] = WDATA_I[`DSCG_WDT_BIT];
      gate_nxt[`DSCG_RATE_HI:`DSCG_RATE_LO] = rate_limit(wr_rate);
    end
  end

  // applied enables; registered so downstream gates see glitch-free levels
  always @* begin
    if (sleep_gated) begin
      clk_en_nxt = deep_en;
    end else begin
      clk_en_nxt = RUN_UNIT_CLOCK_GATE_I;
    end
  end

  // applied rate; the stored deep-sleep field is already clamped
  always @* begin
    if (sleep_gated) begin
      rate_nxt = gate_r[`DSCG_RATE_HI:`DSCG_RATE_LO];
    end else begin
      rate_nxt = rate_limit(RUN_RATE_SELECT_I);
    end
  end

  // access screening: faults decided on the enables in force this cycle
  wire [`DSCG_UNITS-1:0] fault_now;
  wire [`DSCG_UNITS-1:0] done_now;
  assign fault_now = UNIT_ACCESS_I & ~clk_en_r;
  assign done_now = UNIT_ACCESS_I & clk_en_r;

  // lowest faulting unit is recorded when several fault together
  always @* begin
    fault_unit_nxt = fault_unit_r;
    if (fault_now[3]) begin
      fault_unit_nxt = 2'h3;
    end
    if (fault_now[2]) begin
      fault_unit_nxt = 2'h2;
    end
    if (fault_now[1]) begin
      fault_unit_nxt = 2'h1;
    end
    if (fault_now[0]) begin
      fault_unit_nxt = 2'h0;
    end
  end

  // saturating count so software can tell a burst from a single fault
  always @* begin
    fault_count_nxt = fault_count_r;
    if (wr_status & WDATA_I[`DSCG_EV_FAULT]) begin
      fault_count_nxt = 8'h00;
    end
    if ((|fault_now) && (fault_count_nxt != 8'hFF)) begin
      fault_count_nxt = fault_count_nxt + 8'h01;
    end
  end

  // sticky events; a set in the clearing cycle wins
  wire [`DSCG_EV_W-1:0] ev_set;
  assign ev_set[`DSCG_EV_FAULT] = |fault_now;
  assign ev_set[`DSCG_EV_CLAMP] = wr_clamped;
  assign ev_set[`DSCG_EV_APPLY] = sleep_gated ^ sleep_gated_r;

  always @* begin
    status_nxt = status_r;
    if (wr_status) begin
      status_nxt = status_r & ~WDATA_I[`DSCG_EV_W-1:0];
    end
    status_nxt = status_nxt | ev_set;
  end

  // read mux; unmapped offsets and reserved bits read zero
  always @* begin
    rdata_nxt = 32'h00000000;
    if (RD_I) begin
      case (sel)
        5'h01: begin
          rdata_nxt = gate_r & `DSCG_WRITE_MASK;
        end
        5'h02: begin
          rdata_nxt = {29'h0, status_r};
        end
        5'h04: begin
          rdata_nxt = {29'h0, mask_r};
        end
        5'h08: begin
          rdata_nxt = {16'h0000, fault_count_r, 6'h00, fault_unit_r};
        end
        5'h10: begin
          rdata_nxt = {23'h0, sleep_gated_r, 2'h0, rate_r, clk_en_r};
        end
        default: begin
          rdata_nxt = 32'h00000000;
        end
      endcase
    end
  end

  // gate register; hibernation enable is the one bit that resets high
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gate_r <= `DSCG_GATE_RESET;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  // event status; a set in the clearing cycle wins
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      status_r <= 3'h0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // event mask, written whole
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mask_r <= 3'h0;
    end else if (wr_mask) begin
      mask_r <= WDATA_I[`DSCG_EV_W-1:0];
    end
  end

  // fault record
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fault_unit_r <= 2'h0;
      fault_count_r <= 8'h00;
    end else begin
      fault_unit_r <= fault_unit_nxt;
      fault_count_r <= fault_count_nxt;
    end
  end

  // applied enables; all units start unclocked until the first edge
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clk_en_r <= 4'h0;
    end else begin
      clk_en_r <= clk_en_nxt;
    end
  end

  // applied rate starts at the slowest code
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rate_r <= `DSCG_RATE_125K;
    end else begin
      rate_r <= rate_nxt;
    end
  end

  // previous gating mode, for the enter/leave event
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sleep_gated_r <= 1'b0;
    end else begin
      sleep_gated_r <= sleep_gated;
    end
  end

  // access answers, one cycle after the request
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fault_r <= 4'h0;
      done_r <= 4'h0;
    end else begin
      fault_r <= fault_now;
      done_r <= done_now;
    end
  end

  // read data, standing only in the cycle after the strobe
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA_O = rdata_r;
  assign UNIT_CLK_EN_O = clk_en_r;
  assign CONVERTER_RATE_O = rate_r;
  assign BUS_FAULT_O = fault_r;
  assign ACCESS_DONE_O = done_r;
  // level interrupt, high while any unmasked event is pending
  assign IRQ_O = |(status_r & mask_r);

endmodule // deep_sleep_clock_gate_bank0

// ==== src/deep_sleep_clock_gate_map.vh ====
// register map and field layout of the deep-sleep unit clock gate bank
`ifndef DEEP_SLEEP_CLOCK_GATE_MAP_VH
`define DEEP_SLEEP_CLOCK_GATE_MAP_VH

// gating register
`define DSCG_GATE_OFFSET 12'h120
`define DSCG_GATE_RESET 32'h00000040
// event status, write one to clear
`define DSCG_STATUS_OFFSET 12'h130
// event mask, same layout as status
`define DSCG_MASK_OFFSET 12'h134
// last faulting unit and fault count
`define DSCG_FAULT_OFFSET 12'h138
// unit clock enables as currently applied
`define DSCG_APPLIED_OFFSET 12'h13C

// gating register fields
`define DSCG_CAN_BIT 24
`define DSCG_ADC_BIT 16
`define DSCG_RATE_HI 9
`define DSCG_RATE_LO 8
`define DSCG_HIB_BIT 6
`define DSCG_WDT_BIT 3
// writable bits of the gating register
`define DSCG_WRITE_MASK 32'h01010348

// converter sample rate codes
`define DSCG_RATE_125K 2'h0
`define DSCG_RATE_250K 2'h1
`define DSCG_RATE_500K 2'h2

// event status bits
`define DSCG_EV_FAULT 0
`define DSCG_EV_CLAMP 1
`define DSCG_EV_APPLY 2
`define DSCG_EV_W 3

// unit indices
`define DSCG_UNIT_WDT 0
`define DSCG_UNIT_HIB 1
`define DSCG_UNIT_ADC 2
`define DSCG_UNIT_CAN 3
`define DSCG_UNITS 4

`endif

// ==== testbench/deep_sleep_clock_gate_bank0_properties.sv ====
// port checks for the deep-sleep clock gate bank
`timescale 1ns/1ps
module deep_sleep_clock_gate_props #(
  parameter [1:0] MAX_RATE_CODE = 2'h2,
  parameter ADDR_W = 12
) (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire [ADDR_W-1:0] ADDR_I,
  input wire RD_I,
  input wire [31:0] RDATA_O,
  input wire DEEP_SLEEP_I,
  input wire AUTO_CLOCK_GATING_SELECT_I,
  input wire [3:0] RUN_UNIT_CLOCK_GATE_I,
  input wire [1:0] RUN_RATE_SELECT_I,
  input wire [3:0] UNIT_ACCESS_I,
  input wire [3:0] UNIT_CLK_EN_O,
  input wire [1:0] CONVERTER_RATE_O,
  input wire [3:0] BUS_FAULT_O,
  input wire [3:0] ACCESS_DONE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // run mode: gate register not in force, run inputs are
  wire run = !(DEEP_SLEEP_I && AUTO_CLOCK_GATING_SELECT_I);
  wire [1:0] cap = (RUN_RATE_SELECT_I > MAX_RATE_CODE) ? MAX_RATE_CODE : RUN_RATE_SELECT_I;
  wire grd = RD_I && ADDR_I == 12'h120;
  wire any = UNIT_ACCESS_I != 4'h0;
  a_fault_gated: assert property (any |=> BUS_FAULT_O == $past(UNIT_ACCESS_I & ~UNIT_CLK_EN_O))
    else $error("bad fault");
  a_done_clocked: assert property (any |=> ACCESS_DONE_O == $past(UNIT_ACCESS_I & UNIT_CLK_EN_O))
    else $error("bad done");
  a_no_stray_answer: assert property (!any |=> (BUS_FAULT_O | ACCESS_DONE_O) == 4'h0)
    else $error("stray answer");
  a_run_enables: assert property (run |=> UNIT_CLK_EN_O == $past(RUN_UNIT_CLOCK_GATE_I))
    else $error("bad run enables");
  a_run_rate: assert property (run |=> CONVERTER_RATE_O == $past(cap))
    else $error("bad run rate");
  a_rate_capped: assert property (CONVERTER_RATE_O <= MAX_RATE_CODE)
    else $error("rate too high");
  a_read_one_cycle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("stale read data");
  a_reserved_zero: assert property ($past(grd) |-> (RDATA_O & 32'hFEFEFCB7) == 32'h0)
    else $error("reserved bit set");
endmodule // deep_sleep_clock_gate_props
bind deep_sleep_clock_gate_bank0 deep_sleep_clock_gate_props #(.MAX_RATE_CODE(MAX_RATE_CODE), .ADDR_W(ADDR_W)) p (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .DEEP_SLEEP_I(DEEP_SLEEP_I), .AUTO_CLOCK_GATING_SELECT_I(AUTO_CLOCK_GATING_SELECT_I),
  .RUN_UNIT_CLOCK_GATE_I(RUN_UNIT_CLOCK_GATE_I), .RUN_RATE_SELECT_I(RUN_RATE_SELECT_I),
  .UNIT_ACCESS_I(UNIT_ACCESS_I), .UNIT_CLK_EN_O(UNIT_CLK_EN_O), .CONVERTER_RATE_O(CONVERTER_RATE_O),
  .BUS_FAULT_O(BUS_FAULT_O), .ACCESS_DONE_O(ACCESS_DONE_O));

// ==== testbench/tb_deep_sleep_clock_gate_bank0.sv ====
// self-checking bench for the deep-sleep clock gate bank
`timescale 1ns/1ps
module tb_deep_sleep_clock_gate_bank0;
  reg clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, ds = 0, auto_clock_gating_select = 0;
  reg [11:0] addr = 12'h000;
  reg [31:0] wdata = 32'h0, g, e, lfsr = 32'h00005EA0;
  reg [3:0] run = 4'h0, acc = 4'h0, ens;
  reg [1:0] rrate = 2'h0, xr;
  wire [31:0] rdata;
  wire [3:0] en, flt, done;
  wire [1:0] rate;
  wire irq;
  reg [31:0] q[$];
  reg [7:0] uq[$];
  integer num_errors = 0, tests_run = 0, i;
  always #5 clk = ~clk;
  deep_sleep_clock_gate_bank0 dut (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .DEEP_SLEEP_I(ds), .AUTO_CLOCK_GATING_SELECT_I(auto_clock_gating_select), .RUN_UNIT_CLOCK_GATE_I(run),
    .RUN_RATE_SELECT_I(rrate), .UNIT_ACCESS_I(acc), .UNIT_CLK_EN_O(en), .CONVERTER_RATE_O(rate),
    .BUS_FAULT_O(flt), .ACCESS_DONE_O(done), .IRQ_O(irq));
  function [31:0] step(input [31:0] v);
    step = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // readback of a gate write: reserved bits dropped, rate 3 held at the cap
  function [31:0] gexp(input [31:0] d);
    gexp = d & 32'h01010348;
    if (gexp[9:8] == 2'h3) gexp[9:8] = 2'h2;
  endfunction
  task compare(input [31:0] exp, input [31:0] got, input [39:0] what);
    tests_run = tests_run + 1;
    if (exp !== got) begin
      num_errors = num_errors + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus cycle; on a read d is the data expected back
  task bus(input w, input r, input [11:0] a, input [31:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    if (r) q.push_back(d);
    @(posedge clk);
  endtask
  task tick(input integer n);
    repeat (n) bus(0, 0, 12'h000, 32'h0);
  endtask
  // all four units accessed at once, on = enables expected
  task access(input [3:0] on);
    acc <= 4'hF;
    uq.push_back({~on, on});
    tick(1);
    acc <= 4'h0;
  endtask
  task results;
    if (q.size() != 0 || uq.size() != 0) num_errors = num_errors + 1;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // answers matched in order against the oldest note
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) compare(q.pop_front(), rdata, "rdata");
    if ((flt | done) != 4'h0) compare(uq.pop_front(), {flt, done}, "unit");
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors = num_errors + 1;
    results;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    tick(1);
    bus(0, 1, 12'h120, 32'h00000040);
    bus(0, 1, 12'h124, 32'h0);
    // every rate code, random enables, then units judged in run or sleep
    for (i = 0; i < 6; i = i + 1) begin
      lfsr = step(lfsr);
      g = (i == 5) ? 32'hFFFFFFFF : {lfsr[31:10], i[1:0], lfsr[7:0]};
      e = gexp(g);
      bus(1, 0, 12'h120, g);
      bus(0, 1, 12'h120, e);
      ens = (lfsr[16] & lfsr[17]) ? {e[24], e[16], e[6], e[3]} : lfsr[13:10];
      ds <= lfsr[16];
      auto_clock_gating_select <= lfsr[17];
      run <= lfsr[13:10];
      rrate <= lfsr[15:14];
      tick(2);
      xr = (lfsr[16] & lfsr[17]) ? e[9:8] : ((lfsr[15:14] == 2'h3) ? 2'h2 : lfsr[15:14]);
      compare({26'h0, ens, xr}, {26'h0, en, rate}, "apply");
      access(ens);
      tick(1);
    end
    bus(1, 0, 12'h120, e ^ 32'h00000008);
    bus(0, 1, 12'h120, e ^ 32'h00000008);
    ds <= 0;
    run <= 4'h0;
    tick(2);
    access(4'h0);
    // fault event masked, unmasked, then cleared
    for (i = 0; i < 3; i = i + 1) begin
      bus(1, 0, (i == 2) ? 12'h130 : 12'h134, {31'h0, i != 0});
      tick(1);
      compare({31'h0, irq}, {31'h0, i == 1}, "irq");
    end
    rst <= 1;
    tick(2);
    rst <= 0;
    tick(1);
    bus(0, 1, 12'h120, 32'h00000040);
    tick(2);
    results;
  end
endmodule // tb_deep_sleep_clock_gate_bank0
